// >>> logic/start_limit_pkg.sv
/*
  constants shared by the start frequency limiter: setting defaults,
  resolutions, condition codes and timing figures.
  assumes a 50 mhz clock and a periodic program-cycle tick.
*/
package start_limit_pkg;

  localparam int unsigned CLOCK_HZ        = 50_000_000;
  localparam int unsigned SET_W           = 16;     // settings in tenths
  localparam int unsigned CNT_W           = 32;     // stress counter, tenth-second units scaled
  localparam int unsigned STARTS_W        = 7;
  localparam int unsigned HOURS_W         = 7;
  localparam int unsigned TENTHS_PER_HOUR = 36000;

  localparam logic [SET_W-1:0]    HOT_LIMIT_DEF      = 16'h02bc; // 70.0 %
  localparam logic [SET_W-1:0]    STALL_COLD_DEF     = 16'h00c8; // 20.0 s
  localparam logic [SET_W-1:0]    STALL_HOT_DEF      = 16'h0096; // 15.0 s
  localparam logic [STARTS_W-1:0] STARTS_COLD_DEF    = 7'h03;
  localparam logic [STARTS_W-1:0] STARTS_HOT_DEF     = 7'h02;
  localparam logic [HOURS_W-1:0]  WINDOW_HOURS_DEF   = 7'h01;
  localparam logic [SET_W-1:0]    MIN_INTERVAL_DEF   = 16'h00c8; // 20.0 s

  // one tenth of a second at the clock rate
  localparam int unsigned TENTH_NS     = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TENTH_CYCLES = TENTH_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    COND_NORMAL  = 2'h0,
    COND_START   = 2'h1,
    COND_TRIP    = 2'h2,
    COND_BLOCKED = 2'h3
  } cond_t;

endpackage : start_limit_pkg

// >>> logic/start_limiter.sv
/*
  motor start frequency limiter: stress counter, hot/cold rates,
  alarm, restart inhibit and minimum spacing between starts.
  assumes start indication, thermal capacity and thermal-function enable
  arrive synchronous to clock from neighbouring motor functions; the
  settings ports are the shared motor data store and are read live.
*/
// What this block does
// - each detected start adds the applicable safe stall time to the counter
// - every program cycle while enabled and not blocked, the counter drains by allowed starts * stall time per window
// - alarm while exactly one further start remains and no inhibit is active
// - inhibit after last start, held until the counter permits another start
// - inhibit when a start follows the previous sooner than minimum interval
// - while hot, inhibit active and drain at the hot rate
// - when stopped below the hot limit, drain at the cold rate
// - condition code 0 normal, 1 start, 2 trip, 3 blocked
// - hot when used thermal capacity exceeds limit, 0.1 % step, 70 % default
// - cold stall time 0.1 s step, 20.0 s default, hot value when unset
// - hot stall time 0.1 s step, 15.0 s default, used when hot
// - cold allowed starts per window, step 1, default 3
// - hot/cold split only while the thermal overload function is enabled
// - motor data settings come from one shared store
// - starts detected internally from the motor start indication
// - hot allowed starts per window, step 1, default 2
// - window length in whole hours, default 1 h, for both counts
// - minimum interval between starts, 0.1 s step, 20.0 s default
// - blocked output while enabled but prevented from normal operation
module start_limiter
  import start_limit_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TENTH_CYCLES   // program cycle in clocks
) (
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic                enable,
  input  wire logic                block_in,
  input  wire logic                motor_start_indication,
  input  wire logic                motor_running,
  input  wire logic                thermal_overload_function,
  input  wire logic [SET_W-1:0]    thermal_used,
  input  wire logic [SET_W-1:0]    hot_limit,
  input  wire logic [SET_W-1:0]    stall_cold,
  input  wire logic                stall_cold_set,
  input  wire logic [SET_W-1:0]    stall_hot,
  input  wire logic [STARTS_W-1:0] starts_cold,
  input  wire logic [STARTS_W-1:0] starts_hot,
  input  wire logic [HOURS_W-1:0]  window_hours,
  input  wire logic [SET_W-1:0]    min_interval,
  output logic                     alarm,
  output logic                     inhibit,
  output logic                     blocked,
  output logic [1:0]               condition,
  output logic [CNT_W-1:0]         stress_count,
  output logic                     hot
);
  // the widest default budget must fit the counter, else it wraps
  localparam logic [63:0] BUDGET_DEF = 64'(STALL_COLD_DEF) * 64'(TENTHS_PER_HOUR) *
                                       64'(WINDOW_HOURS_DEF) * 64'(STARTS_COLD_DEF);
  initial begin
    if (TICK_CYCLES < 1) $error("start_limiter: TICK_CYCLES must be at least 1");
    if (BUDGET_DEF >= (64'h1 << CNT_W)) $error("start_limiter: CNT_W too narrow for the default settings");
  end

  // program-cycle tick: the counter is kept in tenth-second units
  // scaled by the window length in tenths, so each tick while running drains exactly
  // starts * stall_time with no division hardware
  logic cycle_tick;
  tenth_divider #(.DIV(TICK_CYCLES)) u_div (
    .clock   (clock),
    .reset_n (reset_n),
    .tick    (cycle_tick)
  );

  logic             start_d_r;
  logic [CNT_W-1:0] count_r;
  logic [SET_W-1:0] since_start_r;
  logic             started_once_r;

  wire running     = enable && !block_in;
  // rising edge of the start indication is one start or attempt
  wire start_evt   = running && motor_start_indication && !start_d_r;
  wire hot_class   = thermal_overload_function && (thermal_used > hot_limit);
  // hot rate holds from the moment the motor turns hot until it has both
  // stopped and cooled below the limit; a running motor hovering at the
  // limit keeps the slow drain, which errs on the protective side
  logic rate_hot_r;
  wire  rate_hold  = rate_hot_r && thermal_overload_function && motor_running;
  wire  use_hot    = hot_class || rate_hold;

  wire [SET_W-1:0] cold_time = stall_cold_set ? stall_cold : stall_hot;
  wire [SET_W-1:0] stall_sel = hot_class ? stall_hot : cold_time;
  wire [STARTS_W-1:0] starts_sel = hot_class ? starts_hot : starts_cold;

  // one start's worth of stress: stall * window(tenths), scaled unit
  wire [CNT_W-1:0] win_tenths = CNT_W'(window_hours) * CNT_W'(TENTHS_PER_HOUR);
  wire [CNT_W-1:0] add_amt    = CNT_W'(stall_sel) * win_tenths;
  // per tenth drain equals allowed starts * stall time per window
  wire [CNT_W-1:0] rate_stall = use_hot ? CNT_W'(stall_hot) : CNT_W'(cold_time);
  wire [CNT_W-1:0] rate_start = use_hot ? CNT_W'(starts_hot) : CNT_W'(starts_cold);
  wire [CNT_W-1:0] drain_amt  = rate_stall * rate_start;

  // budget: allowed starts times one start's stress
  wire [CNT_W-1:0] budget     = CNT_W'(starts_sel) * add_amt;
  wire [CNT_W-1:0] headroom   = (count_r >= budget) ? '0 : budget - count_r;
  wire one_left  = (headroom >= add_amt) && (headroom < (add_amt << 1));
  wire none_left = headroom < add_amt;

  wire too_soon  = started_once_r && (since_start_r < min_interval);

  wire [CNT_W-1:0] drained     = (count_r > drain_amt) ? count_r - drain_amt : '0;
  wire             drain_now   = running && cycle_tick;
  wire [CNT_W-1:0] after_drain = drain_now ? drained : count_r;
  // starts keep adding while inhibited; clamp at full scale so a burst
  // cannot wrap the counter round and silently reopen the start budget
  wire [CNT_W:0]   sum_wide    = {1'b0, after_drain} + {1'b0, add_amt};
  wire [CNT_W-1:0] sum_sat     = sum_wide[CNT_W] ? {CNT_W{1'b1}} : sum_wide[CNT_W-1:0];
  wire [CNT_W-1:0] count_nxt   = start_evt ? sum_sat : after_drain;

  // the spacing timer parks at full scale, so a motor idle for hours
  // never wraps back into the too-soon range
  wire             since_full  = (since_start_r == {SET_W{1'b1}});
  wire [SET_W-1:0] since_step  = (cycle_tick && !since_full) ? since_start_r + 1'b1 : since_start_r;
  wire [SET_W-1:0] since_nxt   = start_evt ? '0 : since_step;
  wire             started_nxt = started_once_r || start_evt;

  // previous indication sample; resets low, the idle level, so no false start
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      start_d_r <= 1'b0;
    end else begin
      start_d_r <= motor_start_indication;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rate_hot_r <= 1'b0;
    end else begin
      rate_hot_r <= use_hot;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      since_start_r <= '0;
    end else begin
      since_start_r <= since_nxt;
    end
  end

  // first start arms the spacing check; nothing precedes it to be too close to
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      started_once_r <= 1'b0;
    end else begin
      started_once_r <= started_nxt;
    end
  end

  // outputs registered; the settings ports are the shared store, so an
  // edit made anywhere takes effect here on the next cycle
  wire inhibit_nxt = running && (none_left || too_soon || hot_class);
  wire alarm_nxt   = running && one_left && !inhibit_nxt;
  wire blocked_nxt = enable && block_in;
  // condition priority: blocked, then trip, then start
  cond_t cond_nxt;
  assign cond_nxt = blocked_nxt ? COND_BLOCKED :
                    inhibit_nxt ? COND_TRIP :
                    alarm_nxt   ? COND_START : COND_NORMAL;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alarm <= 1'b0;
    end else begin
      alarm <= alarm_nxt;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      inhibit <= 1'b0;
    end else begin
      inhibit <= inhibit_nxt;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      blocked <= 1'b0;
    end else begin
      blocked <= blocked_nxt;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      condition <= COND_NORMAL;
    end else begin
      condition <= cond_nxt;
    end
  end

  // copy lags the counter by a cycle; fine for display, not for decisions
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stress_count <= '0;
    end else begin
      stress_count <= count_r;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hot <= 1'b0;
    end else begin
      hot <= hot_class;
    end
  end
endmodule : start_limiter

// >>> logic/tenth_divider.sv
/*
  divider producing a one-cycle enable every DIV clock cycles.
  assumes a single clock domain and asynchronous active-low reset.
*/
module tenth_divider
  import start_limit_pkg::*;
#(
  parameter int unsigned DIV = TENTH_CYCLES
) (
  input  wire logic clock,
  input  wire logic reset_n,
  output logic      tick
);
  initial begin
    if (DIV < 1) $error("tenth_divider: DIV must be at least 1");
  end

  logic [31:0] count_r;
  wire         wrap = (count_r == 32'(DIV - 1));

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= 32'h0000_0000;
      tick    <= 1'b0;
    end else begin
      count_r <= wrap ? 32'h0000_0000 : count_r + 32'h0000_0001;
      tick    <= wrap;
    end
  end
endmodule : tenth_divider

// >>> verif/motor_side.sv
/* far-side model: motor status start indication and thermal overload level
   assumes its tasks are called just after a rising clock edge */
module motor_side
  import start_limit_pkg::*;
(
  input  wire logic        clock,
  output logic             motor_start_indication,
  output logic             motor_running,
  output logic             thermal_overload_function,
  output logic [SET_W-1:0] thermal_used
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    motor_start_indication = 1'b0;
    motor_running = 1'b0;
    thermal_overload_function = 1'b0;
    thermal_used = '0;
  end
  // indication held a few cycles, like a real run-up
  task automatic start_motor();
    motor_start_indication = 1'b1;
    motor_running = 1'b1;
    repeat (4) @(posedge clock);
    #1 motor_start_indication = 1'b0;
  endtask : start_motor
  task automatic stop_motor();
    motor_running = 1'b0;
  endtask : stop_motor
  task automatic heat(input logic on, input logic [SET_W-1:0] used);
    thermal_overload_function = on;
    thermal_used = used;
  endtask : heat
endmodule : motor_side

// >>> verif/start_limiter_chk.sv
/* port checks for start_limiter
   assumes one clock domain, bound onto every start_limiter instance */
module start_limiter_chk
  import start_limit_pkg::*;
(
  input wire logic             clock,
  input wire logic             reset_n,
  input wire logic             enable,
  input wire logic             block_in,
  input wire logic             motor_start_indication,
  input wire logic             thermal_overload_function,
  input wire logic [SET_W-1:0] thermal_used,
  input wire logic [SET_W-1:0] hot_limit,
  input wire logic             alarm,
  input wire logic             inhibit,
  input wire logic             blocked,
  input wire logic [1:0]       condition,
  input wire logic [CNT_W-1:0] stress_count,
  input wire logic             hot
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire ok = enable && !block_in;
  property p_blk; $past(reset_n) |-> blocked == $past(enable && block_in); endproperty
  a_blk: assert property (p_blk) else $error("blocked mismatch");
  property p_cond; condition == (blocked ? 2'h3 : inhibit ? 2'h2 : alarm ? 2'h1 : 2'h0); endproperty
  a_cond: assert property (p_cond) else $error("condition code mismatch");
  property p_alm; alarm |-> !inhibit; endproperty
  a_alm: assert property (p_alm) else $error("alarm with inhibit");
  property p_add; $rose(motor_start_indication) && ok |-> ##2 stress_count > $past(stress_count); endproperty
  a_add: assert property (p_add) else $error("start not added");
  property p_why; stress_count > $past(stress_count) |-> $past(motor_start_indication, 2); endproperty
  a_why: assert property (p_why) else $error("count rose without start");
  property p_gap; $rose(motor_start_indication) && ok |-> ##2 inhibit; endproperty
  a_gap: assert property (p_gap) else $error("no spacing inhibit");
  property p_hon; (thermal_overload_function && thermal_used > hot_limit) [*2] |-> hot; endproperty
  a_hon: assert property (p_hon) else $error("hot missed");
  property p_hoff; !thermal_overload_function [*2] |-> !hot; endproperty
  a_hoff: assert property (p_hoff) else $error("hot without thermal function");
  property p_hinh; hot && $past(ok) |-> inhibit; endproperty
  a_hinh: assert property (p_hinh) else $error("hot without inhibit");
  c_alarm: cover property (alarm);
  c_inhibit: cover property (inhibit && !hot);
  c_hot: cover property (hot);
endmodule : start_limiter_chk
bind start_limiter start_limiter_chk chk_u (.clock, .reset_n, .enable, .block_in, .motor_start_indication,
  .thermal_overload_function, .thermal_used, .hot_limit, .alarm, .inhibit, .blocked, .condition,
  .stress_count, .hot);

// >>> verif/tb_top.sv
/* self-checking bench for start_limiter with the motor_side model
   assumes the shortened program cycle of two clocks */
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("FAIL %s exp %0h got %0h", n, e, a); end end
module tb_top import start_limit_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, reset_n = 1'b0, enable = 1'b1, block_in = 1'b0, stall_cold_set = 1'b0;
  logic [SET_W-1:0] hot_limit = HOT_LIMIT_DEF, stall_cold = STALL_COLD_DEF, stall_hot = STALL_HOT_DEF;
  logic [SET_W-1:0] min_interval = MIN_INTERVAL_DEF, thermal_used;
  logic [STARTS_W-1:0] starts_cold = STARTS_COLD_DEF, starts_hot = STARTS_HOT_DEF;
  logic [HOURS_W-1:0] window_hours = WINDOW_HOURS_DEF;
  logic motor_start_indication, motor_running, thermal_overload_function, alarm, inhibit, blocked, hot;
  logic [1:0] condition;
  logic [CNT_W-1:0] stress_count, drain_base;
  int fail_count = 0, total_checks = 0, cycles = 0;
  start_limiter #(.TICK_CYCLES(2)) dut_u (.clock, .reset_n, .enable, .block_in, .motor_start_indication,
    .motor_running, .thermal_overload_function, .thermal_used, .hot_limit, .stall_cold, .stall_cold_set,
    .stall_hot, .starts_cold, .starts_hot, .window_hours, .min_interval, .alarm, .inhibit, .blocked,
    .condition, .stress_count, .hot);
  motor_side ms_u (.clock, .motor_start_indication, .motor_running, .thermal_overload_function, .thermal_used);
  initial forever #10 clock = ~clock;
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic close_out();
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out
  // full drain of one start takes ~24k cycles, so the ceiling sits well above
  always @(posedge clock) begin
    cycles++;
    if (cycles == 50000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    step(2);
    reset_n = 1'b1;
    step(1);
    `CHK("condition", COND_NORMAL, condition)
    ms_u.start_motor();
    step(4);
    `CHK("spacing inhibit", 1'b1, inhibit)
    `CHK("stall", 1'b1, stress_count inside {[32'd5390000:32'd5400000]})
    reset_n = 1'b0;
    stall_cold_set = 1'b1;
    step(2);
    reset_n = 1'b1;
    for (int k = 1; k <= 3; k++) begin
      ms_u.start_motor();
      step(450);
      `CHK("alarm", k == 2, alarm)
      `CHK("inhibit", k == 3, inhibit)
      `CHK("condition", k == 3 ? COND_TRIP : k == 2 ? COND_START : COND_NORMAL, condition)
    end
    for (int i = 0; i < 30000 && inhibit; i++) step(1);
    step(2);
    `CHK("release", 1'b0, inhibit)
    `CHK("one left", 1'b1, alarm)
    ms_u.heat(1'b1, HOT_LIMIT_DEF);
    step(5);
    `CHK("at limit", 1'b0, hot)
    ms_u.heat(1'b1, 16'h0320);
    step(5);
    `CHK("hot", 1'b1, hot)
    `CHK("hot inhibit", 1'b1, inhibit)
    ms_u.stop_motor();
    step(3);
    drain_base = stress_count;
    step(20); // ten program cycles of two clocks each
    `CHK("hot drain", drain_base - CNT_W'(10 * stall_hot * starts_hot), stress_count)
    `CHK("stopped hot inhibit", 1'b1, inhibit)
    ms_u.heat(1'b1, 16'h0100);
    step(3);
    drain_base = stress_count;
    step(20);
    `CHK("cold drain", drain_base - CNT_W'(10 * stall_cold * starts_cold), stress_count)
    ms_u.heat(1'b0, 16'h0320);
    step(5);
    `CHK("no split", 1'b0, hot)
    block_in = 1'b1;
    step(3);
    `CHK("blocked", 1'b1, blocked)
    `CHK("condition", COND_BLOCKED, condition)
    close_out();
  end
endmodule : tb_top
